// *** core/sifm_io_mapper.sv ***
// discrete i/o function mapper of a servo drive: eight inputs, five outputs
// assumes drive status and index status come from logic on aclk;
// terminal pins are asynchronous and are synchronised here
`timescale 1ns/1ps
// Functional notes
// - each input may be set independently active high or active low
// - input n takes code and polarity from configuration register n
// - codes 1 to 10 decode to enable, reset, boost and similar roles
// - codes 11 to 13 form the three-bit position command selection
// - codes 14,15 velocity selection bits; 16,17 torque selection bits
// - codes 21 to 23 are normally closed; deasserted input triggers them
// - codes 25 and 26 request reverse and forward torque limiting
// - code 27 starts a homing move
// - codes 28 to 32 form the five-bit index selection value
// - codes 33 and 34 form the two-bit index control value
// - code 35 manual continuous indexing, code 36 manual single step
// - codes 37,38 jog; step codes 39,40 only in indexer modes
// - code 41 only in automatic indexing; code 42 selects automatic indexing
// - codes 43 and 44 select the electronic gear numerator
// - code 45 blocks the terminal pulse command
// - output mode 0: each output takes code and polarity from its register
// - output mode 1 in indexer modes: outputs show the binary index status
// - output codes 1 to 10 report ready through overload warning
// - speed-reached output works in every mode except the two position modes
// - in-position output works only in position and mixed position modes
// - homing-completed output works only in pulse, indexer and mixed position modes
module sifm_io_mapper #(
   parameter int NUM_DI = sifm_pkg::SIFM_NUM_DI,
   parameter int NUM_DO = sifm_pkg::SIFM_NUM_DO
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sifm_pkg::SIFM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [sifm_pkg::SIFM_DATA_W-1:0] s_axi_wdata,
   input wire logic [sifm_pkg::SIFM_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sifm_pkg::SIFM_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [sifm_pkg::SIFM_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_DI-1:0] discrete_input,
   input wire logic [sifm_pkg::SIFM_NUM_DO_CODES:1] drive_status,
   input wire logic [NUM_DO-1:0] index_status_code,
   output logic [sifm_pkg::SIFM_NUM_DI_CODES:1] di_func,
   output logic [sifm_pkg::SIFM_POS_SEL_W-1:0] pos_cmd_sel,
   output logic [sifm_pkg::SIFM_VEL_SEL_W-1:0] vel_cmd_sel,
   output logic [sifm_pkg::SIFM_TRQ_SEL_W-1:0] trq_cmd_sel,
   output logic [sifm_pkg::SIFM_IDX_SEL_W-1:0] index_sel,
   output logic [sifm_pkg::SIFM_IDX_CTL_W-1:0] index_ctl,
   output logic [sifm_pkg::SIFM_GEAR_SEL_W-1:0] gear_num_sel,
   output logic [NUM_DO-1:0] discrete_output
);
   import sifm_pkg::*;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [SIFM_CODE_W-1:0] di_code [NUM_DI];
   logic [NUM_DI-1:0] di_pol;
   logic [SIFM_CODE_W-1:0] do_code [NUM_DO];
   logic [NUM_DO-1:0] do_pol;
   logic out_mode;
   sifm_ctrl_mode_t ctrl_mode;
   logic aw_full, w_full, do_write, wr_mode_sel, wr_ctrl_sel, wr_ro_sel, wr_hit, rd_ok;
   logic [SIFM_ADDR_W-1:0] aw_addr_q;
   logic [SIFM_DATA_W-1:0] w_data_q, rd_word;
   logic [SIFM_STRB_W-1:0] w_strb_q;
   logic [NUM_DI-1:0] wr_di_sel, di_asserted, di_assigned;
   logic [NUM_DO-1:0] wr_do_sel;

   // write channel handshakes; address and data may come in either order
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // write address decode
   assign wr_mode_sel = aw_addr_q == SIFM_OFF_OUT_MODE;
   assign wr_ctrl_sel = aw_addr_q == SIFM_OFF_CTRL_MODE;
   assign wr_ro_sel = aw_addr_q == SIFM_OFF_DI_FUNC_LO || aw_addr_q == SIFM_OFF_DI_FUNC_HI
      || aw_addr_q == SIFM_OFF_DO_STATE || aw_addr_q == SIFM_OFF_DI_STATE;
   assign wr_hit = (|wr_di_sel) || (|wr_do_sel) || wr_mode_sel || wr_ctrl_sel || wr_ro_sel;

   // write channel state: hold each half until both are present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SIFM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? SIFM_RESP_OKAY : SIFM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // per-input configuration registers, lowest register feeds input 1
   for (genvar i = 0; i < NUM_DI; i++) begin : g_di_cfg
      assign wr_di_sel[i] =
         aw_addr_q == SIFM_OFF_DI_CFG + SIFM_ADDR_W'(i * SIFM_REG_STRIDE);
      assign di_assigned[i] = di_code[i] != SIFM_CODE_RST;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            di_code[i] <= SIFM_CODE_RST;
            di_pol[i] <= SIFM_POL_RST;
         end else if (do_write && wr_di_sel[i]) begin
            if (w_strb_q[SIFM_CODE_LANE])
               di_code[i] <= w_data_q[SIFM_CFG_CODE_LSB +: SIFM_CODE_W];
            if (w_strb_q[SIFM_POL_LANE])
               di_pol[i] <= w_data_q[SIFM_CFG_POL_BIT];
         end
      end
   end

   // per-output configuration registers
   for (genvar o = 0; o < NUM_DO; o++) begin : g_do_cfg
      assign wr_do_sel[o] =
         aw_addr_q == SIFM_OFF_DO_CFG + SIFM_ADDR_W'(o * SIFM_REG_STRIDE);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            do_code[o] <= SIFM_CODE_RST;
            do_pol[o] <= SIFM_POL_RST;
         end else if (do_write && wr_do_sel[o]) begin
            if (w_strb_q[SIFM_CODE_LANE])
               do_code[o] <= w_data_q[SIFM_CFG_CODE_LSB +: SIFM_CODE_W];
            if (w_strb_q[SIFM_POL_LANE])
               do_pol[o] <= w_data_q[SIFM_CFG_POL_BIT];
         end
      end
   end

   // global selectors; an out-of-range control mode value is ignored, output mode takes bit 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_mode <= SIFM_OUT_MODE_RST;
         ctrl_mode <= SIFM_MODE_RST;
      end else if (do_write && w_strb_q[SIFM_CODE_LANE]) begin
         if (wr_mode_sel)
            out_mode <= w_data_q[SIFM_CFG_CODE_LSB];
         if (wr_ctrl_sel && w_data_q[SIFM_MODE_W-1:0] <= SIFM_MODE_S_T)
            ctrl_mode <= sifm_ctrl_mode_t'(w_data_q[SIFM_MODE_W-1:0]);
      end
   end

   // read decode straight from the request address
   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      if (s_axi_araddr == SIFM_OFF_OUT_MODE) begin
         rd_word[SIFM_CFG_CODE_LSB] = out_mode;
      end else if (s_axi_araddr == SIFM_OFF_CTRL_MODE) begin
         rd_word[SIFM_MODE_W-1:0] = ctrl_mode;
      end else if (s_axi_araddr == SIFM_OFF_DI_FUNC_LO) begin
         rd_word = di_func[SIFM_FUNC_LO_W:1];
      end else if (s_axi_araddr == SIFM_OFF_DI_FUNC_HI) begin
         rd_word[SIFM_NUM_DI_CODES-SIFM_FUNC_LO_W-1:0] =
            di_func[SIFM_NUM_DI_CODES:SIFM_FUNC_LO_W+1];
      end else if (s_axi_araddr == SIFM_OFF_DO_STATE) begin
         rd_word[NUM_DO-1:0] = discrete_output;
      end else if (s_axi_araddr == SIFM_OFF_DI_STATE) begin
         rd_word[NUM_DI-1:0] = di_asserted;
      end else begin
         rd_ok = 1'b0;
         for (int k = 0; k < NUM_DI; k++) begin
            if (s_axi_araddr == SIFM_OFF_DI_CFG + SIFM_ADDR_W'(k * SIFM_REG_STRIDE)) begin
               rd_word[SIFM_CFG_CODE_LSB +: SIFM_CODE_W] = di_code[k];
               rd_word[SIFM_CFG_POL_BIT] = di_pol[k];
               rd_ok = 1'b1;
            end
         end
         for (int k = 0; k < NUM_DO; k++) begin
            if (s_axi_araddr == SIFM_OFF_DO_CFG + SIFM_ADDR_W'(k * SIFM_REG_STRIDE)) begin
               rd_word[SIFM_CFG_CODE_LSB +: SIFM_CODE_W] = do_code[k];
               rd_word[SIFM_CFG_POL_BIT] = do_pol[k];
               rd_ok = 1'b1;
            end
         end
      end
   end

   // read data register; one read in flight at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= SIFM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? SIFM_RESP_OKAY : SIFM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // input function decode
   // ---------------------------------------------------------------
   logic [NUM_DI-1:0] hit_on [1:SIFM_NUM_DI_CODES], hit_off [1:SIFM_NUM_DI_CODES];
   logic [SIFM_NUM_DI_CODES:1] func_raw, func_gate, next_di_func;
   logic is_pr, is_auto;
   // one synchroniser and polarity stage per terminal
   for (genvar i = 0; i < NUM_DI; i++) begin : g_sense
      sifm_di_sense u_sense (
         .aclk(aclk),
         .aresetn(aresetn),
         .pin(discrete_input[i]),
         .active_low(di_pol[i]),
         .asserted(di_asserted[i])
      );
   end

   // several terminals on one code are or-ed; code 0 and codes above 45 match nothing
   for (genvar c = 1; c <= SIFM_NUM_DI_CODES; c++) begin : g_code
      for (genvar i = 0; i < NUM_DI; i++) begin : g_term
         assign hit_on[c][i] = di_asserted[i] && di_code[i] == SIFM_CODE_W'(c);
         assign hit_off[c][i] = !di_asserted[i] && di_code[i] == SIFM_CODE_W'(c);
      end
      if (c >= SIFM_DI_FAULT_STOP && c <= SIFM_DI_FWD_INHIBIT) begin : g_nc
         assign func_raw[c] = |hit_off[c];
      end else begin : g_no
         assign func_raw[c] = |hit_on[c];
      end
   end

   // indexer-only functions are masked outside the internal indexer modes
   assign is_pr = ctrl_mode == SIFM_MODE_PR || ctrl_mode == SIFM_MODE_PR_S
      || ctrl_mode == SIFM_MODE_PR_T;
   assign is_auto = is_pr && func_raw[SIFM_DI_AUTO_INDEX];
   always_comb begin
      func_gate = '1;
      func_gate[SIFM_DI_POS_PAUSE] = is_pr;
      func_gate[SIFM_DI_STEP_REV] = is_pr;
      func_gate[SIFM_DI_STEP_FWD] = is_pr;
      func_gate[SIFM_DI_RET_INDEX1] = is_auto;
   end
   assign next_di_func = func_raw & func_gate;

   // registered function flags and packed selection values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         di_func <= '0;
         pos_cmd_sel <= '0;
         vel_cmd_sel <= '0;
         trq_cmd_sel <= '0;
         index_sel <= '0;
         index_ctl <= '0;
         gear_num_sel <= '0;
      end else begin
         di_func <= next_di_func;
         pos_cmd_sel <= next_di_func[SIFM_DI_POS_CMD_SEL_BIT0 +: SIFM_POS_SEL_W];
         vel_cmd_sel <= next_di_func[SIFM_DI_VEL_CMD_SEL_BIT0 +: SIFM_VEL_SEL_W];
         trq_cmd_sel <= next_di_func[SIFM_DI_TRQ_CMD_SEL_BIT0 +: SIFM_TRQ_SEL_W];
         index_sel <= next_di_func[SIFM_DI_INDEX_SEL_BIT0 +: SIFM_IDX_SEL_W];
         index_ctl <= next_di_func[SIFM_DI_INDEX_CTL_BIT0 +: SIFM_IDX_CTL_W];
         gear_num_sel <= next_di_func[SIFM_DI_GEAR0 +: SIFM_GEAR_SEL_W];
      end
   end

   // ---------------------------------------------------------------
   // output function select
   // ---------------------------------------------------------------
   logic [SIFM_NUM_DO_CODES:1] mode_ok, allowed_status;
   logic [NUM_DO-1:0] do_func, next_discrete_output;
   logic use_binary, pos_family, trq_family;
   // status that a mode does not support reads inactive
   assign pos_family = ctrl_mode != SIFM_MODE_S && ctrl_mode != SIFM_MODE_T
      && ctrl_mode != SIFM_MODE_S_T;
   assign trq_family = ctrl_mode == SIFM_MODE_T || ctrl_mode == SIFM_MODE_PT_T
      || ctrl_mode == SIFM_MODE_PR_T || ctrl_mode == SIFM_MODE_S_T;
   always_comb begin
      mode_ok = '1;
      mode_ok[SIFM_DO_SPEED_REACHED] = ctrl_mode != SIFM_MODE_PT
         && ctrl_mode != SIFM_MODE_PR;
      mode_ok[SIFM_DO_IN_POSITION] = pos_family;
      mode_ok[SIFM_DO_TRQ_LIMIT] = trq_family;
      mode_ok[SIFM_DO_HOMED] = pos_family;
   end
   assign allowed_status = drive_status & mode_ok;

   // binary index status only makes sense while the indexer runs
   assign use_binary = out_mode && is_pr;

   for (genvar o = 0; o < NUM_DO; o++) begin : g_do
      assign do_func[o] = (do_code[o] >= SIFM_CODE_W'(SIFM_DO_READY)
         && do_code[o] <= SIFM_CODE_W'(SIFM_NUM_DO_CODES))
         ? allowed_status[do_code[o]] : 1'b0;
      assign next_discrete_output[o] = use_binary ? index_status_code[o]
         : do_func[o] ^ do_pol[o];
   end

   // output terminals from flops so the pins never glitch
   always_ff @(posedge aclk) begin
      if (!aresetn)
         discrete_output <= '0;
      else
         discrete_output <= next_discrete_output;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_SERVO_EN: assert property (di_code[0] == SIFM_CODE_W'(SIFM_DI_SERVO_EN)
      && di_asserted[0] |=> di_func[SIFM_DI_SERVO_EN]) else $error("servo enable not decoded");
   AST_POS_SEL: assert property ($past(aresetn) |->
      pos_cmd_sel == $past(func_raw[SIFM_DI_POS_CMD_SEL_BIT0 +: SIFM_POS_SEL_W]))
      else $error("position selection wrong");
   AST_NC_FAULT: assert property (di_code[NUM_DI-1] == SIFM_CODE_W'(SIFM_DI_FAULT_STOP)
      && !di_asserted[NUM_DI-1] |=> di_func[SIFM_DI_FAULT_STOP])
      else $error("fault stop sense not inverted");
   AST_STEP_GATE: assert property (!is_pr |=> !di_func[SIFM_DI_STEP_REV]
      && !di_func[SIFM_DI_STEP_FWD]) else $error("step function outside indexer mode");
   AST_RET_GATE: assert property (!is_auto |=> !di_func[SIFM_DI_RET_INDEX1])
      else $error("return to index outside auto mode");
   AST_UNASSIGNED: assert property (!(|di_assigned) |=> di_func == '0)
      else $error("unassigned input had an effect");
   AST_DO_READY: assert property (!use_binary && do_code[0] == SIFM_CODE_W'(SIFM_DO_READY)
      |=> discrete_output[0] == ($past(drive_status[SIFM_DO_READY]) ^ $past(do_pol[0])))
      else $error("ready output level wrong");
   AST_DO_BINARY: assert property (use_binary |=>
      discrete_output == $past(index_status_code))
      else $error("binary index status not shown");
   AST_SPEED_GATE: assert property (ctrl_mode == SIFM_MODE_PT && !use_binary
      && do_code[1] == SIFM_CODE_W'(SIFM_DO_SPEED_REACHED) |=> discrete_output[1] ==
      $past(do_pol[1])) else $error("speed reached driven in position mode");
   AST_INPOS_GATE: assert property (ctrl_mode == SIFM_MODE_S && do_code[2] ==
      SIFM_CODE_W'(SIFM_DO_IN_POSITION) |=> discrete_output[2] == $past(do_pol[2]))
      else $error("in position driven in velocity mode");
   AST_HOME_GATE: assert property (ctrl_mode == SIFM_MODE_T
      && do_code[2] == SIFM_CODE_W'(SIFM_DO_HOMED) |=> discrete_output[2] == $past(do_pol[2]))
      else $error("homing done driven in torque mode");
   AST_BRESP: assert property (do_write |=> s_axi_bvalid && !aw_full && !w_full)
      else $error("write response missing");
   CVR_BINARY: cover property (use_binary ##1 discrete_output != '0);
   CVR_NC_TRIP: cover property (di_func[SIFM_DI_FAULT_STOP]);
   CVR_AUTO_RET: cover property (di_func[SIFM_DI_RET_INDEX1]);
   CVR_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// *** core/sifm_pkg.sv ***
// shared constants and types of the servo discrete i/o function mapper
// assumes one 100 MHz drive clock and an AXI4-Lite register port
package sifm_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int SIFM_NUM_DI = 8;
   localparam int SIFM_NUM_DO = 5;
   localparam int SIFM_CODE_W = 6;
   localparam int SIFM_NUM_DI_CODES = 45;
   localparam int SIFM_NUM_DO_CODES = 10;
   localparam int SIFM_ADDR_W = 8;
   localparam int SIFM_DATA_W = 32;
   localparam int SIFM_STRB_W = 4;
   localparam int SIFM_MODE_W = 4;
   localparam int SIFM_POS_SEL_W = 3;
   localparam int SIFM_VEL_SEL_W = 2;
   localparam int SIFM_TRQ_SEL_W = 2;
   localparam int SIFM_IDX_SEL_W = 5;
   localparam int SIFM_IDX_CTL_W = 2;
   localparam int SIFM_GEAR_SEL_W = 2;
   localparam int SIFM_FUNC_LO_W = 32;
   localparam int SIFM_REG_STRIDE = 4;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_DI_CFG = 8'h00;
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_DO_CFG = 8'h20;
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_OUT_MODE = 8'h34;
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_CTRL_MODE = 8'h38;
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_DI_FUNC_LO = 8'h40;
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_DI_FUNC_HI = 8'h44;
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_DO_STATE = 8'h48;
   localparam logic [SIFM_ADDR_W-1:0] SIFM_OFF_DI_STATE = 8'h4C;
   localparam int SIFM_CFG_CODE_LSB = 0;
   localparam int SIFM_CFG_POL_BIT = 8;
   localparam int SIFM_CODE_LANE = 0;
   localparam int SIFM_POL_LANE = 1;
   localparam logic [SIFM_CODE_W-1:0] SIFM_CODE_RST = 6'h00;
   localparam logic SIFM_POL_RST = 1'b0;
   localparam logic SIFM_OUT_MODE_RST = 1'b0;
   localparam logic [1:0] SIFM_RESP_OKAY = 2'h0;
   localparam logic [1:0] SIFM_RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // input function codes
   // ---------------------------------------------------------------
   localparam int SIFM_DI_SERVO_EN = 1;
   localparam int SIFM_DI_POS_PAUSE = 7;
   localparam int SIFM_DI_POS_CMD_SEL_BIT0 = 11;
   localparam int SIFM_DI_VEL_CMD_SEL_BIT0 = 14;
   localparam int SIFM_DI_TRQ_CMD_SEL_BIT0 = 16;
   localparam int SIFM_DI_FAULT_STOP = 21;
   localparam int SIFM_DI_FWD_INHIBIT = 23;
   localparam int SIFM_DI_TRQ_LIM_REV = 25;
   localparam int SIFM_DI_TRQ_LIM_FWD = 26;
   localparam int SIFM_DI_HOME_START = 27;
   localparam int SIFM_DI_INDEX_SEL_BIT0 = 28;
   localparam int SIFM_DI_INDEX_CTL_BIT0 = 33;
   localparam int SIFM_DI_MAN_CONT = 35;
   localparam int SIFM_DI_MAN_STEP = 36;
   localparam int SIFM_DI_STEP_REV = 39;
   localparam int SIFM_DI_STEP_FWD = 40;
   localparam int SIFM_DI_RET_INDEX1 = 41;
   localparam int SIFM_DI_AUTO_INDEX = 42;
   localparam int SIFM_DI_GEAR0 = 43;
   localparam int SIFM_DI_PULSE_INH = 45;

   // ---------------------------------------------------------------
   // output function codes
   // ---------------------------------------------------------------
   localparam int SIFM_DO_READY = 1;
   localparam int SIFM_DO_SPEED_REACHED = 4;
   localparam int SIFM_DO_IN_POSITION = 5;
   localparam int SIFM_DO_TRQ_LIMIT = 6;
   localparam int SIFM_DO_HOMED = 9;

   // control modes of the drive
   typedef enum logic [SIFM_MODE_W-1:0] {
      SIFM_MODE_PT, SIFM_MODE_PR, SIFM_MODE_S, SIFM_MODE_T, SIFM_MODE_PT_S,
      SIFM_MODE_PT_T, SIFM_MODE_PR_S, SIFM_MODE_PR_T, SIFM_MODE_S_T
   } sifm_ctrl_mode_t;
   localparam sifm_ctrl_mode_t SIFM_MODE_RST = SIFM_MODE_PT;
endpackage

// *** core/sifm_di_sense.sv ***
// one discrete input terminal: pin synchroniser and active-level select
// assumes the pin is asynchronous to aclk
`timescale 1ns/1ps
module sifm_di_sense (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   input wire logic active_low,
   output logic asserted
);
   import sifm_pkg::*;

   logic sync1;
   logic sync2;

   // two-stage synchroniser, then polarity; sync1 feeds sync2 only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         asserted <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         asserted <= sync2 ^ active_low;
      end
   end

   // three edges clear of reset: the pin of three edges back, corrected by the setting
   AST_DI_SENSE: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3)
      |-> asserted == ($past(pin, 3) ^ $past(active_low)))
      else $error("input sense level wrong");
endmodule

// *** testbench/sifm_ctrl_model.sv ***
// partner model: outside controller wiring the discrete input terminals
// assumes the bench picks the wanted contact levels
`timescale 1ns/1ps
module sifm_ctrl_model (
   input wire logic aclk,
   input wire logic [7:0] want,
   output logic [7:0] discrete_input
);
   // contacts settle one cycle late, unrelated to any bus activity
   always @(posedge aclk) begin
      discrete_input <= want;
   end
endmodule

// *** testbench/sifm_io_mapper_bench.sv ***
// bench for the discrete i/o mapper: AXI4-Lite tasks and terminal levels
// assumes the design asserts its own rules internally
`timescale 1ns/1ps
module sifm_io_mapper_bench;
   import sifm_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = '0, araddr = '0, want = '0, din;
   logic [31:0] wdata = '0, rdata;
   logic [1:0] bresp, rresp;
   logic [10:1] ds = '0;
   logic [4:0] isc = '0, dout, idx;
   logic [45:1] di_func;
   logic [2:0] pos;
   logic [1:0] vel, trq, ictl, gear;
   int n_fail = 0, n_compared = 0;
   always #5 aclk = ~aclk;
   sifm_ctrl_model u_sifm_ctrl_model (.aclk(aclk), .want(want), .discrete_input(din));
   sifm_io_mapper u_sifm_io_mapper (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .discrete_input(din), .drive_status(ds), .index_status_code(isc), .di_func(di_func),
      .pos_cmd_sel(pos), .vel_cmd_sel(vel), .trq_cmd_sel(trq), .index_sel(idx),
      .index_ctl(ictl), .gear_num_sel(gear), .discrete_output(dout));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // write; a leading edge keeps bready from being set twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         t++;
      end while (!bvalid && t < 50);
      bready <= 1'h0;
      chk("write answer", {bvalid, bresp}, 3'h4);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      int t = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         t++;
      end while (!rvalid && t < 50);
      rready <= 1'h0;
      chk("read answer", {rvalid, rresp}, {1'h1, er});
      chk("read data", rdata, ed);
   endtask
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      rd(8'h00, 2'h0, 32'h0);
      rd(8'hFC, 2'h2, 32'h0);
      wr(8'h00, 32'h001);
      want <= 8'h01;
      repeat (8) @(posedge aclk);
      chk("enable func", di_func[1], 32'h1);
      wr(8'h00, 32'h101);
      wr(8'h04, 32'h0D);
      wr(8'h08, 32'h20);
      wr(8'h1C, 32'h15);
      want <= 8'h0E;
      repeat (8) @(posedge aclk);
      rd(8'h40, 2'h0, 32'h80101001);
      chk("pos sel", pos, 32'h4);
      chk("index sel", idx, 32'h10);
      want <= 8'h8E;
      repeat (8) @(posedge aclk);
      chk("fault stop", di_func[21], 32'h0);
      $display("inputs test done");
      ds <= 10'h119;
      wr(8'h20, 32'h01);
      repeat (3) @(posedge aclk);
      chk("outputs", dout, 32'h01);
      wr(8'h20, 32'h101);
      wr(8'h24, 32'h04);
      wr(8'h28, 32'h05);
      repeat (3) @(posedge aclk);
      chk("outputs", dout, 32'h04);
      wr(8'h38, 32'h2);
      repeat (3) @(posedge aclk);
      chk("outputs", dout, 32'h02);
      isc <= 5'h15;
      wr(8'h38, 32'h1);
      wr(8'h34, 32'h1);
      repeat (3) @(posedge aclk);
      chk("outputs", dout, 32'h15);
      $display("outputs test done");
      wr(8'h04, 32'h0E);
      wr(8'h08, 32'h11);
      wr(8'h0C, 32'h27);
      wr(8'h10, 32'h22);
      wr(8'h14, 32'h2C);
      want <= 8'hBE;
      repeat (8) @(posedge aclk);
      chk("selections", {vel, trq, ictl, gear}, 32'h6A);
      chk("step reverse", di_func[39], 32'h1);
      wr(8'h28, 32'h09);
      wr(8'h38, 32'h3);
      repeat (3) @(posedge aclk);
      chk("step reverse", di_func[39], 32'h0);
      chk("outputs", dout, 32'h02);
      $display("selection test done");
      give_verdict;
   end
   // tests need about 140 cycles; 20 us leaves wide margin
   initial begin
      #20us;
      n_fail++;
      give_verdict;
   end
endmodule
